// *** rtl/flash_pm_params.svh ***
`ifndef FLASH_PM_PARAMS_SVH
`define FLASH_PM_PARAMS_SVH

// system clock period
`define CLK_PERIOD_NS      50

// power mode and configuration program timing, in ns
`define DS_ENTRY_NS        3000
`define DS_WAKE_NS         35000
`define US_ENTRY_NS        3000
`define US_EXIT_NS         70000
`define CS_LOW_PULSE_NS    20
`define CFG_PROG_NS        50000000

// timer width, wide enough for the configuration program count
`define TMR_W              20

// opcodes, configuration sequence bytes and byte counts
`define OP_DEEP_SLEEP      8'hB9
`define OP_DEEP_WAKE       8'hAB
`define OP_ULTRA_SLEEP     8'h79
`define OP_STATUS_READ     8'hD7
`define CFG_BYTE0          8'h3D
`define CFG_BYTE1          8'h2A
`define CFG_BYTE2          8'h80
`define CFG_BYTE3_256      8'hA6
`define CFG_BYTE3_264      8'hA7
`define CFG_LEN            3'h4
`define BYTE_CNT_MAX       3'h5

// status byte layout
`define ST_READY_BIT       7
`define ST_PAGE_BIT        0
`define ST_DENSITY         4'h5
`define ST_DENSITY_LSB     2

// factory page size setting: 1 selects 256 bytes
`define NV_FACTORY_256     1'b1

`endif

// *** rtl/flash_pm_pkg.sv ***
`default_nettype none
package flash_pm_pkg;

   typedef enum logic [2:0] {
      PM_STANDBY,
      PM_DS_ENTRY,
      PM_DEEP,
      PM_DS_WAKE,
      PM_US_ENTRY,
      PM_ULTRA,
      PM_US_EXIT
   } pm_state_t;

endpackage
`default_nettype wire

// *** rtl/nv_cfg_store.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_pm_params.svh"

module nv_cfg_store (
   input  wire logic clock,
   input  wire logic factory_init,
   input  wire logic wr_en,
   input  wire logic wr_data,
   output logic      rd_q
);

   logic cell_q;
   logic cell_d;

   // no link to rst: the setting must survive a power cycle
   always_comb begin
      cell_d = cell_q;
      if (factory_init) begin
         cell_d = `NV_FACTORY_256;
      end else if (wr_en) begin
         cell_d = wr_data;
      end
   end

   always_ff @(posedge clock) begin
      cell_q <= cell_d;
      rd_q   <= cell_d;
   end

endmodule

`default_nettype wire

// *** rtl/flash_power_mode_and_page_size_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_pm_params.svh"

module flash_power_mode_and_page_size_ctrl #(
   parameter int unsigned CFG_PROG_CYCLES = `CFG_PROG_NS / `CLK_PERIOD_NS
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic factory_init,
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic si,
   input  wire logic ext_busy,
   output logic      so,
   output logic      so_oe,
   output logic      ready,
   output logic      standby,
   output logic      deep_sleep,
   output logic      ultra_sleep,
   output logic      buffer_discard,
   output logic      page_size_256
);

   ////////////////////////////////////////////////////////////////////////////
   // timing counts

   // longest times round down, least times round up, none below one cycle
   function automatic int unsigned cyc_floor(input int unsigned ns);
      cyc_floor = (ns / `CLK_PERIOD_NS) > 0 ? ns / `CLK_PERIOD_NS : 1;
   endfunction

   function automatic int unsigned cyc_ceil(input int unsigned ns);
      cyc_ceil = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
      if (cyc_ceil == 0) begin
         cyc_ceil = 1;
      end
   endfunction

   localparam logic [`TMR_W-1:0] DS_ENTRY_CYC = `TMR_W'(cyc_floor(`DS_ENTRY_NS));
   localparam logic [`TMR_W-1:0] DS_WAKE_CYC  = `TMR_W'(cyc_floor(`DS_WAKE_NS));
   localparam logic [`TMR_W-1:0] US_ENTRY_CYC = `TMR_W'(cyc_floor(`US_ENTRY_NS));
   localparam logic [`TMR_W-1:0] US_EXIT_CYC  = `TMR_W'(cyc_floor(`US_EXIT_NS));
   localparam logic [`TMR_W-1:0] CS_LOW_CYC   = `TMR_W'(cyc_ceil(`CS_LOW_PULSE_NS));
   localparam logic [`TMR_W-1:0] PROG_CYC     = `TMR_W'(CFG_PROG_CYCLES);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // expected byte of the size configuration sequence at a given position
   function automatic logic cfg_byte_ok(input logic [2:0] idx, input logic [7:0] b);
      case (idx)
         3'h0:    cfg_byte_ok = (b == `CFG_BYTE0);
         3'h1:    cfg_byte_ok = (b == `CFG_BYTE1);
         3'h2:    cfg_byte_ok = (b == `CFG_BYTE2);
         3'h3:    cfg_byte_ok = (b == `CFG_BYTE3_256) || (b == `CFG_BYTE3_264);
         default: cfg_byte_ok = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] status_byte(input logic second, input logic rdy,
                                              input logic p256);
      status_byte = 8'h00;
      status_byte[`ST_READY_BIT] = rdy;
      if (!second) begin
         status_byte[`ST_DENSITY_LSB +: 4] = `ST_DENSITY;
         status_byte[`ST_PAGE_BIT]         = p256;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin edges

   logic sck_q;
   logic cs_n_q;
   logic sck_rise;
   logic sck_fall;
   logic frame_start;
   logic frame_end;

   always_ff @(posedge clock) begin
      if (rst) begin
         sck_q  <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sck_q  <= sck;
         cs_n_q <= cs_n;
      end
   end

   assign sck_rise    = sck & ~sck_q & ~cs_n;
   assign sck_fall    = ~sck & sck_q & ~cs_n;
   assign frame_start = ~cs_n & cs_n_q;
   assign frame_end   = cs_n & ~cs_n_q;

   ////////////////////////////////////////////////////////////////////////////
   // command shifter

   flash_pm_pkg::pm_state_t pm_q;
   flash_pm_pkg::pm_state_t pm_d;

   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [2:0] bitcnt_q;
   logic [2:0] bitcnt_d;
   logic [2:0] bytecnt_q;
   logic [2:0] bytecnt_d;
   logic [7:0] op_q;
   logic [7:0] op_d;
   logic       cfg_ok_q;
   logic       cfg_ok_d;
   logic       cfg_256_q;
   logic       cfg_256_d;
   logic       frame_ok_q;
   logic       frame_ok_d;
   logic       byte_done;
   logic [7:0] rx_byte;

   assign rx_byte   = {shift_q[6:0], si};
   assign byte_done = sck_rise && (bitcnt_q == 3'h7);

   always_comb begin
      shift_d    = shift_q;
      bitcnt_d   = bitcnt_q;
      bytecnt_d  = bytecnt_q;
      op_d       = op_q;
      cfg_ok_d   = cfg_ok_q;
      cfg_256_d  = cfg_256_q;
      frame_ok_d = frame_ok_q;
      if (frame_start) begin
         bitcnt_d   = 3'h0;
         bytecnt_d  = 3'h0;
         cfg_ok_d   = 1'b0;
         // frames opened in a transition or ultra sleep are dropped whole
         frame_ok_d = (pm_q == flash_pm_pkg::PM_STANDBY) ||
                      (pm_q == flash_pm_pkg::PM_DEEP);
      end else if (sck_rise) begin
         shift_d  = rx_byte;
         bitcnt_d = bitcnt_q + 3'h1;
         if (byte_done) begin
            if (bytecnt_q == 3'h0) begin
               op_d = rx_byte;
            end
            if (bytecnt_q == 3'h3) begin
               cfg_256_d = (rx_byte == `CFG_BYTE3_256);
            end
            cfg_ok_d = ((bytecnt_q == 3'h0) || cfg_ok_q) &&
                       cfg_byte_ok(bytecnt_q, rx_byte);
            if (bytecnt_q != `BYTE_CNT_MAX) begin
               bytecnt_d = bytecnt_q + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         shift_q    <= 8'h00;
         bitcnt_q   <= 3'h0;
         bytecnt_q  <= 3'h0;
         op_q       <= 8'h00;
         cfg_ok_q   <= 1'b0;
         cfg_256_q  <= 1'b0;
         frame_ok_q <= 1'b0;
      end else begin
         shift_q    <= shift_d;
         bitcnt_q   <= bitcnt_d;
         bytecnt_q  <= bytecnt_d;
         op_q       <= op_d;
         cfg_ok_q   <= cfg_ok_d;
         cfg_256_q  <= cfg_256_d;
         frame_ok_q <= frame_ok_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power modes and configuration program

   logic [`TMR_W-1:0] tmr_q;
   logic [`TMR_W-1:0] tmr_d;
   logic [`TMR_W-1:0] low_q;
   logic [`TMR_W-1:0] low_d;
   logic [`TMR_W-1:0] prog_cnt_q;
   logic [`TMR_W-1:0] prog_cnt_d;
   logic              prog_q;
   logic              prog_d;
   logic              nv_wr_q;
   logic              nv_wr_d;
   logic              nv_data_q;
   logic              nv_data_d;
   logic              discard_d;
   logic              busy;
   logic              has_op;
   logic              cmd_end;
   logic              nv_256;

   assign busy    = prog_q | ext_busy;
   assign has_op  = bytecnt_q != 3'h0;
   assign cmd_end = frame_end && frame_ok_q;

   always_comb begin
      pm_d       = pm_q;
      tmr_d      = tmr_q + `TMR_W'(1);
      low_d      = low_q;
      prog_d     = prog_q;
      prog_cnt_d = prog_cnt_q;
      nv_wr_d    = 1'b0;
      nv_data_d  = nv_data_q;
      discard_d  = 1'b0;
      case (pm_q)
         flash_pm_pkg::PM_STANDBY: begin
            tmr_d = '0;
            // extra bytes after a sleep opcode do not matter
            if (cmd_end && has_op && !busy) begin
               if (op_q == `OP_DEEP_SLEEP) begin
                  pm_d = flash_pm_pkg::PM_DS_ENTRY;
               end else if (op_q == `OP_ULTRA_SLEEP) begin
                  pm_d = flash_pm_pkg::PM_US_ENTRY;
               end else if (cfg_ok_q && bytecnt_q == `CFG_LEN && bitcnt_q == 3'h0) begin
                  prog_d     = 1'b1;
                  prog_cnt_d = '0;
                  nv_data_d  = cfg_256_q;
               end
            end
         end
         flash_pm_pkg::PM_DS_ENTRY: begin
            if (tmr_q == DS_ENTRY_CYC - `TMR_W'(1)) begin
               pm_d = flash_pm_pkg::PM_DEEP;
            end
         end
         flash_pm_pkg::PM_DEEP: begin
            tmr_d = '0;
            // only the wake opcode is honoured here
            if (cmd_end && has_op && op_q == `OP_DEEP_WAKE) begin
               pm_d = flash_pm_pkg::PM_DS_WAKE;
            end
         end
         flash_pm_pkg::PM_DS_WAKE: begin
            if (tmr_q == DS_WAKE_CYC - `TMR_W'(1)) begin
               pm_d = flash_pm_pkg::PM_STANDBY;
            end
         end
         flash_pm_pkg::PM_US_ENTRY: begin
            if (tmr_q == US_ENTRY_CYC - `TMR_W'(1)) begin
               pm_d      = flash_pm_pkg::PM_ULTRA;
               discard_d = 1'b1;
            end
         end
         flash_pm_pkg::PM_ULTRA: begin
            tmr_d = '0;
            // bytes clocked in during the pulse are never decoded
            if (cs_n) begin
               low_d = '0;
            end else if (low_q != CS_LOW_CYC) begin
               low_d = low_q + `TMR_W'(1);
            end
            if (frame_end && low_q == CS_LOW_CYC) begin
               pm_d = flash_pm_pkg::PM_US_EXIT;
            end
         end
         flash_pm_pkg::PM_US_EXIT: begin
            if (tmr_q == US_EXIT_CYC - `TMR_W'(1)) begin
               pm_d = flash_pm_pkg::PM_STANDBY;
            end
         end
         default: begin
            pm_d = flash_pm_pkg::PM_STANDBY;
         end
      endcase
      if (prog_q) begin
         prog_cnt_d = prog_cnt_q + `TMR_W'(1);
         if (prog_cnt_q == PROG_CYC - `TMR_W'(1)) begin
            // the new size is visible one cycle after the program ends
            prog_d  = 1'b0;
            nv_wr_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pm_q       <= flash_pm_pkg::PM_STANDBY;
         tmr_q      <= '0;
         low_q      <= '0;
         prog_q     <= 1'b0;
         prog_cnt_q <= '0;
         nv_wr_q    <= 1'b0;
         nv_data_q  <= 1'b0;
      end else begin
         pm_q       <= pm_d;
         tmr_q      <= tmr_d;
         low_q      <= low_d;
         prog_q     <= prog_d;
         prog_cnt_q <= prog_cnt_d;
         nv_wr_q    <= nv_wr_d;
         nv_data_q  <= nv_data_d;
      end
   end

   nv_cfg_store u_nv (
      .clock        (clock),
      .factory_init (factory_init),
      .wr_en        (nv_wr_q),
      .wr_data      (nv_data_q),
      .rd_q         (nv_256)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status output and mode flags

   logic       stat_on_q;
   logic       stat_on_d;
   logic [6:0] tx_q;
   logic [6:0] tx_d;
   logic [2:0] tx_bits_q;
   logic [2:0] tx_bits_d;
   logic       tx_second_q;
   logic       tx_second_d;
   logic       so_d;
   logic       so_oe_d;
   logic [7:0] tx_load;

   assign tx_load = status_byte(tx_second_q, ~busy, nv_256);

   always_comb begin
      stat_on_d   = stat_on_q;
      tx_d        = tx_q;
      tx_bits_d   = tx_bits_q;
      tx_second_d = tx_second_q;
      so_d        = so;
      so_oe_d     = so_oe;
      if (cs_n) begin
         stat_on_d   = 1'b0;
         tx_bits_d   = 3'h0;
         tx_second_d = 1'b0;
         so_oe_d     = 1'b0;
      end else if (byte_done && bytecnt_q == 3'h0 && rx_byte == `OP_STATUS_READ &&
                   frame_ok_q && pm_q == flash_pm_pkg::PM_STANDBY) begin
         // the status read is allowed during a self-timed operation
         stat_on_d = 1'b1;
      end else if (sck_fall && stat_on_q) begin
         // status is sampled byte by byte so busy stays current
         if (tx_bits_q == 3'h0) begin
            so_d = tx_load[7];
            tx_d = tx_load[6:0];
         end else begin
            so_d = tx_q[6];
            tx_d = {tx_q[5:0], 1'b0};
         end
         so_oe_d   = 1'b1;
         tx_bits_d = tx_bits_q + 3'h1;
         if (tx_bits_q == 3'h7) begin
            tx_second_d = ~tx_second_q;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         stat_on_q   <= 1'b0;
         tx_q        <= 7'h00;
         tx_bits_q   <= 3'h0;
         tx_second_q <= 1'b0;
         so          <= 1'b0;
         so_oe       <= 1'b0;
         ready       <= 1'b0;
         standby     <= 1'b0;
         deep_sleep  <= 1'b0;
         ultra_sleep <= 1'b0;
         buffer_discard <= 1'b0;
         page_size_256  <= 1'b0;
      end else begin
         stat_on_q   <= stat_on_d;
         tx_q        <= tx_d;
         tx_bits_q   <= tx_bits_d;
         tx_second_q <= tx_second_d;
         so          <= so_d;
         so_oe       <= so_oe_d;
         ready       <= ~busy;
         standby     <= (pm_q == flash_pm_pkg::PM_STANDBY) && cs_n && !busy;
         deep_sleep  <= (pm_q == flash_pm_pkg::PM_DEEP);
         ultra_sleep <= (pm_q == flash_pm_pkg::PM_ULTRA);
         buffer_discard <= discard_d;
         page_size_256  <= nv_256;
      end
   end

endmodule

`default_nettype wire

// *** verif/flash_pm_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_pm_chk #(
   parameter int unsigned CFG_PROG_CYCLES = 20
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic factory_init,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic si,
   input wire logic ext_busy,
   input wire logic so,
   input wire logic so_oe,
   input wire logic ready,
   input wire logic standby,
   input wire logic deep_sleep,
   input wire logic ultra_sleep,
   input wire logic buffer_discard,
   input wire logic page_size_256
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // time spent outside every settled mode; a stuck transition never ends
   logic [31:0] trans_run_q;
   logic [31:0] trans_run_d;

   always_comb begin
      trans_run_d = (!standby && !deep_sleep && !ultra_sleep) ? trans_run_q + 32'h1 : 32'h0;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         trans_run_q <= 32'h0;
      end else begin
         trans_run_q <= trans_run_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   a_sleep_quiet: assert property (
      (deep_sleep || ultra_sleep) |-> !so_oe)
      else $error("serial output driven while asleep");
   a_one_mode: assert property (
      standby |-> !deep_sleep && !ultra_sleep)
      else $error("standby together with a sleep mode");
   a_standby_idle: assert property (
      (!cs_n || ext_busy)[*4] |-> !standby)
      else $error("standby while selected or busy");
   a_busy_no_sleep: assert property (
      !ready |=> !$rose(deep_sleep) && !$rose(ultra_sleep))
      else $error("sleep entered while busy");
   a_discard_entry: assert property (
      $rose(ultra_sleep) |-> buffer_discard || $past(buffer_discard) || $past(buffer_discard, 2))
      else $error("ultra sleep entered without buffer discard");
   a_discard_pulse: assert property (
      buffer_discard |=> !buffer_discard)
      else $error("buffer discard longer than one cycle");
   a_wake_time: assert property (
      $fell(deep_sleep) |-> ##[1:800] standby)
      else $error("wake from deep sleep too slow");
   a_trans_bound: assert property (
      trans_run_q <= 32'(CFG_PROG_CYCLES) + 32'h708)
      else $error("mode transition did not settle");
   a_so_release: assert property (
      cs_n[*4] |-> !so_oe)
      else $error("serial output driven while deselected");
   a_cfg_hold: assert property (
      $fell(ready) && !ext_busy && !$past(ext_busy) |-> (!ready)[*8])
      else $error("configuration program too short");
   a_factory_size: assert property (
      factory_init |-> ##2 page_size_256)
      else $error("factory setting did not select the 256-byte page");
   a_status_ready: assert property (
      $rose(so_oe) |-> so == ready)
      else $error("first status bit differs from the ready flag");
   a_so_on_fall: assert property (
      $changed(so) |-> !$past(sck))
      else $error("serial output moved outside a clock fall");
endmodule

bind flash_power_mode_and_page_size_ctrl flash_pm_chk #(
   .CFG_PROG_CYCLES(CFG_PROG_CYCLES)
) chk_u (
   .clock(clock), .rst(rst), .factory_init(factory_init), .sck(sck), .cs_n(cs_n),
   .si(si), .ext_busy(ext_busy), .so(so), .so_oe(so_oe), .ready(ready),
   .standby(standby), .deep_sleep(deep_sleep), .ultra_sleep(ultra_sleep),
   .buffer_discard(buffer_discard), .page_size_256(page_size_256)
);
`default_nettype wire

// *** verif/flash_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_host_model #(
   parameter int HALF = 3
) (
   input  wire logic clock,
   input  wire logic so,
   input  wire logic so_oe,
   output logic      cs_n,
   output logic      sck,
   output logic      si
);
   logic [7:0] rx_byte;
   event       got_byte;

   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      rx_byte = 8'h00;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clock);
   endtask

   // mode 0, msb first; cut drops trailing bits to build an aborted frame
   task automatic frame(input logic [7:0] tx[$], input int cut, input int nread);
      int   nbits;
      logic oe_all;
      nbits = tx.size() * 8 - cut;
      @(posedge clock);
      cs_n <= 1'b0;
      hold(HALF);
      for (int i = 0; i < nbits; i++) begin
         si <= tx[i / 8][7 - i % 8];
         hold(HALF);
         sck <= 1'b1;
         hold(HALF);
         sck <= 1'b0;
      end
      for (int b = 0; b < nread; b++) begin
         oe_all = 1'b1;
         for (int i = 7; i >= 0; i--) begin
            hold(HALF - 1);
            @(negedge clock);
            rx_byte[i] = so;
            oe_all &= so_oe;
            @(posedge clock);
            sck <= 1'b1;
            hold(HALF);
            sck <= 1'b0;
         end
         // only driven bytes are reported, so a silent device gives no result
         if (oe_all) begin
            -> got_byte;
         end
      end
      hold(HALF);
      cs_n <= 1'b1;
      si <= ~si;
      hold(HALF);
   endtask

   task automatic pulse(input int n);
      @(posedge clock);
      cs_n <= 1'b0;
      hold(n);
      cs_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** verif/flash_power_mode_and_page_size_ctrl_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_power_mode_and_page_size_ctrl_test;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       factory_init = 1'b1;
   logic       ext_busy = 1'b0;
   wire logic  cs_n, sck, si, so, so_oe;
   wire logic  ready, standby, deep_sleep, ultra_sleep, buffer_discard, page_size_256;
   int         mismatches = 0;
   int         total_checks = 0;
   int         discards = 0;
   logic [7:0] exp_q[$];
   logic [7:0] junk;

   always #25 clock = ~clock;

   flash_host_model host_u (
      .clock(clock), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si)
   );

   flash_power_mode_and_page_size_ctrl #(
      .CFG_PROG_CYCLES(20)
   ) dut_u (
      .clock(clock), .rst(rst), .factory_init(factory_init), .sck(sck), .cs_n(cs_n),
      .si(si), .ext_busy(ext_busy), .so(so), .so_oe(so_oe), .ready(ready),
      .standby(standby), .deep_sleep(deep_sleep), .ultra_sleep(ultra_sleep),
      .buffer_discard(buffer_discard), .page_size_256(page_size_256)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic logic [7:0] flags();
      return {3'h0, page_size_256, standby, deep_sleep, ultra_sleep, ready};
   endfunction

   task automatic settle(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic wait_flags(input logic [7:0] exp, input int limit);
      int n = 0;
      while (flags() !== exp && n < limit) begin
         @(negedge clock);
         n++;
      end
   endtask

   // a status byte reaching the host is matched against the oldest note
   always @(host_u.got_byte) begin
      check(host_u.rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
   end

   // each entry into ultra sleep must throw the buffer away exactly once
   always @(negedge clock) begin
      if (buffer_discard === 1'b1) begin
         discards++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      junk = 8'($urandom(90524));
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      factory_init <= 1'b0;
      wait_flags(8'h19, 8);
      check(flags(), 8'h19);
      exp_q.push_back(8'h95);
      exp_q.push_back(8'h80);
      host_u.frame('{8'hD7}, 0, 2);
      host_u.frame('{8'hB9}, 1 + $urandom % 7, 0);
      settle(80);
      check(flags(), 8'h19);
      host_u.frame('{8'hB9, 8'($urandom)}, 0, 0);
      wait_flags(8'h15, 70);
      check(flags(), 8'h15);
      host_u.frame('{8'hD7}, 0, 2);
      host_u.frame('{8'h79}, 0, 0);
      host_u.frame('{8'hAB}, 1 + $urandom % 7, 0);
      settle(80);
      check(flags(), 8'h15);
      host_u.frame('{8'hAB, 8'($urandom)}, 0, 0);
      wait_flags(8'h19, 720);
      check(flags(), 8'h19);
      @(posedge clock);
      ext_busy <= 1'b1;
      host_u.frame('{8'hB9}, 0, 0);
      host_u.frame('{8'h79}, 0, 0);
      host_u.frame('{8'h3D, 8'h2A, 8'h80, 8'hA7}, 0, 0);
      settle(80);
      check(flags(), 8'h10);
      @(posedge clock);
      ext_busy <= 1'b0;
      wait_flags(8'h19, 8);
      check(flags(), 8'h19);
      host_u.frame('{8'h79, 8'($urandom)}, 0, 0);
      wait_flags(8'h13, 70);
      check(flags(), 8'h13);
      host_u.frame('{8'hD7}, 0, 2);
      host_u.frame('{8'hB9}, 0, 0);
      wait_flags(8'h19, 1420);
      check(flags(), 8'h19);
      settle(80);
      check(flags(), 8'h19);
      host_u.frame('{8'h79}, 0, 0);
      wait_flags(8'h13, 70);
      check(flags(), 8'h13);
      host_u.frame('{8'($urandom)}, 0, 0);
      wait_flags(8'h19, 1420);
      check(flags(), 8'h19);
      host_u.frame('{8'h79}, 0, 0);
      wait_flags(8'h13, 70);
      check(flags(), 8'h13);
      host_u.pulse(2);
      wait_flags(8'h19, 1420);
      check(flags(), 8'h19);
      host_u.frame('{8'h3D, 8'h2A, 8'h80, 8'hA7}, 0, 0);
      settle(6);
      check(flags(), 8'h10);
      wait_flags(8'h09, 40);
      check(flags(), 8'h09);
      exp_q.push_back(8'h94);
      exp_q.push_back(8'h80);
      host_u.frame('{8'hD7}, 0, 2);
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      wait_flags(8'h09, 8);
      check(flags(), 8'h09);
      host_u.frame('{8'h3D, 8'h2A, 8'h80, 8'hA6, 8'($urandom)}, 0, 0);
      settle(40);
      check(flags(), 8'h09);
      host_u.frame('{8'h3D, 8'h2A, 8'h80, 8'hA6}, 0, 0);
      wait_flags(8'h19, 40);
      check(flags(), 8'h19);
      // only a handful of size switches per run keeps the register wear low
      host_u.frame('{8'h3D, 8'h2A, 8'h80, 8'hA7}, 0, 0);
      wait_flags(8'h09, 40);
      check(flags(), 8'h09);
      @(posedge clock);
      factory_init <= 1'b1;
      @(posedge clock);
      factory_init <= 1'b0;
      wait_flags(8'h19, 8);
      check(flags(), 8'h19);
      check(8'(discards), 8'h03);
      check(8'(exp_q.size()), 8'h00);
      complete_run();
   end

   // the sequence needs about 8000 cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
